// ===== include/fbd_pkg.sv
// Package for the filament bridge drive block: register map, fields, frame timing
package fbd_pkg;
  // ----------------------------------------
  // Register map (printed offsets are not multiples of four: index * 4)
  // ----------------------------------------
  localparam logic [7:0] FBD_IDX_DUTY = 8'h09;
  localparam logic [7:0] FBD_IDX_PHASE_A_SEL = 8'h0A;
  localparam logic [7:0] FBD_IDX_PHASE_B_SEL = 8'h0B;
  localparam logic [7:0] FBD_IDX_CTRL = 8'h0E;
  localparam logic [7:0] FBD_IDX_STATUS = 8'h0F;
  localparam int FBD_ADDR_W = 8;
  // ----------------------------------------
  // Reset values and fields
  // ----------------------------------------
  localparam logic [7:0] FBD_DUTY_RST = 8'h01;
  localparam logic [1:0] FBD_SEL_RST = 2'h0;
  localparam int FBD_SEL_LSB = 0;
  localparam int FBD_CTRL_SHDN_BIT = 0;
  localparam int FBD_CTRL_BLINK_BIT = 1;
  localparam logic [1:0] FBD_SEL_LOW = 2'h0;
  localparam logic [1:0] FBD_SEL_HIGH = 2'h1;
  localparam logic [1:0] FBD_SEL_BLINK = 2'h2;
  localparam logic [1:0] FBD_SEL_DRIVE = 2'h3;
  // ----------------------------------------
  // Frame timing in oscillator cycles
  // ----------------------------------------
  localparam logic [8:0] FBD_IDLE_BASE = 9'h0C7;
  localparam logic [8:0] FBD_GAP_CYCLES = 9'h002;
  localparam logic [8:0] FBD_FRAME_CYCLES = 9'h190;
  localparam logic [7:0] FBD_DUTY_MAX = 8'hC7;
  localparam logic [7:0] FBD_DUTY_MIN = 8'h01;
  // Frame segments, one-hot
  typedef enum logic [4:0] {
    FBD_SEG_IDLE1 = 5'b0_0001,
    FBD_SEG_ACT_B = 5'b0_0010,
    FBD_SEG_GAP = 5'b0_0100,
    FBD_SEG_ACT_A = 5'b0_1000,
    FBD_SEG_IDLE2 = 5'b1_0000
  } fbd_seg_type;
endpackage

// ===== rtl/fbd_top.sv
// Filament bridge drive: frame generator, pin selectors and Avalon-MM registers
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Each 400-cycle frame runs idle, first active, 2-cycle gap, second active, idle.
// - In the first active segment phase B is high and phase A low for the on-count.
// - In the second active segment phase A is high and phase B low for the on-count.
// - The frame always totals 400 oscillator cycles whatever the on-count.
// - The phase A selector at 0x0A decodes D1:D0 only; 00 low after reset, 01 high.
// - Selector code 10 puts the blink phase on the pin: low first phase, high second.
// - Selector code 11 puts drive phase A on the pin, forced low in shutdown.
// - Phase B selector at 0x0B with code 11 gives drive phase B, low in shutdown.
module fbd_top
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Avalon-MM slave
  input wire logic [fbd_pkg::FBD_ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Device state
  input wire logic shutdown,
  input wire logic blink_phase_second,
  // Bridge pins
  output logic filament_phase_a,
  output logic filament_phase_b
);
  import fbd_pkg::*;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] duty_r;
  logic [1:0] sel_a_r;
  logic [1:0] sel_b_r;
  logic [7:0] on_count_r;
  // Frame state
  logic [8:0] frame_cnt_r;
  fbd_seg_type seg_r;
  fbd_seg_type seg_nxt;
  logic frame_last;
  logic ack_r;
  logic [FBD_ADDR_W-1:0] idx;
  logic req;
  logic wr_en;
  logic drive_a;
  logic drive_b;
  logic pin_a_nxt;
  logic pin_b_nxt;

  // Byte address to register index
  assign idx = {2'b00, avs_address[FBD_ADDR_W-1:2]};
  assign req = (avs_read | avs_write) & ~ack_r;
  assign wr_en = avs_write & ack_r & avs_byteenable[0];

  // ----------------------------------------
  // Bus handshake: one wait cycle, then answer
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      ack_r <= 1'b0;
    else
      ack_r <= req;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      avs_waitrequest <= 1'b1;
    else
      avs_waitrequest <= ~req;
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      duty_r <= FBD_DUTY_RST;
      sel_a_r <= FBD_SEL_RST;
      sel_b_r <= FBD_SEL_RST;
    end
    else if (wr_en)
    begin
      if (idx == FBD_IDX_DUTY)
        duty_r <= avs_writedata[7:0];
      if (idx == FBD_IDX_PHASE_A_SEL)
        sel_a_r <= avs_writedata[FBD_SEL_LSB +: 2];
      if (idx == FBD_IDX_PHASE_B_SEL)
        sel_b_r <= avs_writedata[FBD_SEL_LSB +: 2];
    end
  end

  // ----------------------------------------
  // Register reads, unmapped reads as zero
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read & ~ack_r)
    begin
      unique case (idx)
        FBD_IDX_DUTY: avs_readdata <= {24'h00_0000, duty_r};
        FBD_IDX_PHASE_A_SEL: avs_readdata <= {30'h0000_0000, sel_a_r};
        FBD_IDX_PHASE_B_SEL: avs_readdata <= {30'h0000_0000, sel_b_r};
        FBD_IDX_STATUS: avs_readdata <= {15'h0000, seg_r, frame_cnt_r, on_count_r[2:0]};
        FBD_IDX_CTRL: avs_readdata <= {30'h0000_0000, blink_phase_second, shutdown};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------
  // Frame sequencer
  // ----------------------------------------
  // Bounds from frame position, so zero-length segments vanish
  always_comb
  begin
    if (frame_cnt_r < FBD_IDLE_BASE - {1'b0, on_count_r})
      seg_nxt = FBD_SEG_IDLE1;
    else if (frame_cnt_r < FBD_IDLE_BASE)
      seg_nxt = FBD_SEG_ACT_B;
    else if (frame_cnt_r < FBD_IDLE_BASE + FBD_GAP_CYCLES)
      seg_nxt = FBD_SEG_GAP;
    else if (frame_cnt_r < FBD_IDLE_BASE + FBD_GAP_CYCLES + {1'b0, on_count_r})
      seg_nxt = FBD_SEG_ACT_A;
    else
      seg_nxt = FBD_SEG_IDLE2;
  end

  // Segment lags frame position by one cycle, lengths unchanged
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      seg_r <= FBD_SEG_IDLE1;
    else
      seg_r <= seg_nxt;
  end

  // ----------------------------------------
  // Frame position
  // ----------------------------------------
  assign frame_last = (frame_cnt_r == FBD_FRAME_CYCLES - 9'h001);

  // Whole-frame counter keeps every frame at 400 cycles
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      frame_cnt_r <= 9'h000;
    else if (frame_last)
      frame_cnt_r <= 9'h000;
    else
      frame_cnt_r <= frame_cnt_r + 9'h001;
  end

  // ----------------------------------------
  // On-count latch
  // ----------------------------------------
  // On-count latched at frame start, clamped to FBD_DUTY_MAX at the top only, with no floor at FBD_DUTY_MIN
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      on_count_r <= FBD_DUTY_RST;
    else if (frame_last)
    begin
      if (duty_r > FBD_DUTY_MAX)
        on_count_r <= FBD_DUTY_MAX;
      else
        on_count_r <= duty_r;
    end
  end

  // ----------------------------------------
  // Pin selectors
  // ----------------------------------------
  assign drive_a = (seg_r == FBD_SEG_ACT_A) & ~shutdown;
  assign drive_b = (seg_r == FBD_SEG_ACT_B) & ~shutdown;

  always_comb
  begin
    unique case (sel_a_r)
      FBD_SEL_LOW: pin_a_nxt = 1'b0;
      FBD_SEL_HIGH: pin_a_nxt = 1'b1;
      FBD_SEL_BLINK: pin_a_nxt = blink_phase_second;
      FBD_SEL_DRIVE: pin_a_nxt = drive_a;
    endcase
  end

  always_comb
  begin
    unique case (sel_b_r)
      FBD_SEL_LOW: pin_b_nxt = 1'b0;
      FBD_SEL_HIGH: pin_b_nxt = 1'b1;
      FBD_SEL_BLINK: pin_b_nxt = blink_phase_second;
      FBD_SEL_DRIVE: pin_b_nxt = drive_b;
    endcase
  end

  // Registered pins, one cycle behind the segment
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      filament_phase_a <= 1'b0;
      filament_phase_b <= 1'b0;
    end
    else
    begin
      filament_phase_a <= pin_a_nxt;
      filament_phase_b <= pin_b_nxt;
    end
  end
endmodule
`default_nettype wire

// ===== tb/fbd_bridge_model.sv
// Bridge model: measures each gate conduction length
`timescale 1ns/1ps
`default_nettype none
module fbd_bridge_model
(
  // Clock and reset
  input wire logic clk,
  input wire logic nrst,
  // Gate drives
  input wire logic filament_phase_a,
  input wire logic filament_phase_b,
  // Last conduction lengths
  output logic [8:0] len_a_r,
  output logic [8:0] len_b_r
);
  logic [8:0] run_a_r;
  logic [8:0] run_b_r;
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      {run_a_r, len_a_r} <= '0;
    else if (filament_phase_a)
      run_a_r <= run_a_r + 9'h001;
    else if (run_a_r != '0)
      {run_a_r, len_a_r} <= {9'h000, run_a_r};
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      {run_b_r, len_b_r} <= '0;
    else if (filament_phase_b)
      run_b_r <= run_b_r + 9'h001;
    else if (run_b_r != '0)
      {run_b_r, len_b_r} <= {9'h000, run_b_r};
endmodule
`default_nettype wire

// ===== tb/fbd_top_assertions.sv
// Checker for the filament bridge drive ports
`timescale 1ns/1ps
`default_nettype none
module fbd_top_chk
(
  // Clock, reset, bus
  input wire logic clk,
  input wire logic nrst,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Device state and pins
  input wire logic shutdown,
  input wire logic filament_phase_a,
  input wire logic filament_phase_b
);
  logic [8:0] hi_a_r;
  logic [8:0] hi_b_r;
  logic [8:0] per_r;
  logic seen_r;
  logic [8:0] lb_r;
  logic ok_r;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Pulse lengths and spacing of phase B falling edges (gap starts)
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
      {hi_a_r, hi_b_r, per_r, seen_r, lb_r, ok_r} <= '0;
    else
    begin
      hi_a_r <= filament_phase_a ? hi_a_r + 9'h001 : 9'h000;
      hi_b_r <= filament_phase_b ? hi_b_r + 9'h001 : 9'h000;
      per_r <= $fell(filament_phase_b) ? 9'h001 : per_r + 9'h001;
      seen_r <= !shutdown && (seen_r || $fell(filament_phase_b));
      lb_r <= $fell(filament_phase_b) ? hi_b_r : lb_r;
      ok_r <= !shutdown && (ok_r || ($fell(filament_phase_b) && seen_r));
    end
  a_no_overlap: assert property (
    !(filament_phase_a && filament_phase_b)) else $error("both phases high");
  a_gap_two: assert property (
    disable iff (!nrst || shutdown)
    $fell(filament_phase_b) |-> !filament_phase_a [*2] ##1 filament_phase_a)
    else $error("dead gap not two cycles");
  a_pulse_max: assert property (
    hi_a_r <= 9'h0C7 && hi_b_r <= 9'h0C7) else $error("pulse above 199");
  a_frame_400: assert property (
    disable iff (!nrst || shutdown)
    $fell(filament_phase_b) && seen_r |-> per_r == 9'h190) else $error("frame not 400");
  a_wait_one: assert property (
    $rose(avs_read || avs_write) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("answer not after one wait");
  a_wait_pulse: assert property (
    !avs_waitrequest |=> avs_waitrequest) else $error("answer too long");
  a_wait_cause: assert property (
    !avs_waitrequest |-> $past(avs_read || avs_write)) else $error("answer unasked");
  a_pair_equal: assert property (
    disable iff (!nrst || shutdown)
    $fell(filament_phase_a) && ok_r |-> hi_a_r == lb_r) else $error("phases differ in a frame");
  a_read_upper: assert property (
    !avs_waitrequest && avs_read |-> avs_readdata[31:17] == '0) else $error("upper bits set");
endmodule
bind fbd_top fbd_top_chk u_chk (.clk, .nrst, .avs_read, .avs_write, .avs_readdata,
  .avs_waitrequest, .shutdown, .filament_phase_a, .filament_phase_b);
`default_nettype wire

// ===== tb/fbd_top_test.sv
// Testbench for the filament bridge drive
`timescale 1ns/1ps
`default_nettype none
module fbd_top_test;
  import fbd_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic shutdown = 1'b0;
  logic blink_phase_second = 1'b0;
  logic filament_phase_a;
  logic filament_phase_b;
  logic [8:0] len_a;
  logic [8:0] len_b;
  logic [31:0] q;
  logic hi = 1'b0;
  logic [7:0] duty_v [4] = '{8'h01, 8'h64, 8'hC6, 8'hC7};
  logic [8:0] duty_e [4] = '{9'h001, 9'h064, 9'h0C6, 9'h0C7};
  int bad_count = 0;
  int n_checks = 0;
  always #20 clk = ~clk;
  fbd_top uut (.clk(clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .shutdown(shutdown),
    .blink_phase_second(blink_phase_second), .filament_phase_a(filament_phase_a),
    .filament_phase_b(filament_phase_b));
  fbd_bridge_model u_bridge (.clk(clk), .nrst(nrst), .filament_phase_a(filament_phase_a),
    .filament_phase_b(filament_phase_b), .len_a_r(len_a), .len_b_r(len_b));
  task finish_test;
    if (bad_count == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input string name, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    i = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= {24'h00_0000, d};
    avs_write <= w;
    avs_read <= !w;
    do
    begin
      @(posedge clk);
      i++;
    end
    while (avs_waitrequest !== 1'b0 && i < 50);
    if (i == 50)
      bad_count++;
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  initial
  begin
    #800000;
    bad_count++;
    finish_test;
  end
  initial
  begin
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    xfer(1'b0, 8'h24, 8'h00);
    chk("duty_reset", 32'h0000_0001, q);
    xfer(1'b0, 8'h28, 8'h00);
    chk("sel_a_reset", 32'h0000_0000, q);
    xfer(1'b0, 8'h40, 8'h00);
    chk("unmapped", 32'h0000_0000, q);
    chk("pin_a_reset", 32'h0000_0000, filament_phase_a);
    for (int c = 0; c < 4; c++)
    begin
      blink_phase_second <= (c == 3);
      xfer(1'b1, 8'h28, 8'hF0 | 8'((c < 3) ? c : 2));
      repeat (3) @(posedge clk);
      chk("pin_a_static", c == 1 || c == 3, filament_phase_a);
    end
    xfer(1'b1, 8'h28, 8'hF3);
    xfer(1'b1, 8'h2C, 8'h03);
    for (int k = 0; k < 4; k++)
    begin
      @(negedge filament_phase_b);
      xfer(1'b1, 8'h24, duty_v[k]);
      repeat (1000) @(posedge clk);
      chk("len_a", duty_e[k], len_a);
      chk("len_b", duty_e[k], len_b);
    end
    shutdown <= 1'b1;
    repeat (3) @(posedge clk);
    repeat (400)
    begin
      @(posedge clk);
      hi = hi | filament_phase_a | filament_phase_b;
    end
    chk("shutdown_pins", 32'h0000_0000, hi);
    xfer(1'b0, 8'h38, 8'h00);
    chk("ctrl_view", 32'h0000_0003, q);
    xfer(1'b1, 8'h24, 8'h64);
    shutdown <= 1'b0;
    repeat (900) @(posedge clk);
    chk("len_a_resume", 32'h0000_0064, len_a);
    chk("len_b_resume", 32'h0000_0064, len_b);
    finish_test;
  end
endmodule
`default_nettype wire
